// ### inc/bgtm_map.svh
/*
 * Register indices, field positions, reset values and count targets
 * for the background light threshold monitor.
 * Assumes inclusion by bare name; definitions only.
 */
`ifndef BGTM_MAP_SVH
`define BGTM_MAP_SVH
// Register indices; byte address is index times four
`define BGTM_IDX_STATUS   8'h04
`define BGTM_IDX_CNT_A    8'h16
`define BGTM_IDX_CNT_B    8'h1C
`define BGTM_IDX_GAIN     8'h44
`define BGTM_IDX_PATH     8'h45
`define BGTM_IDX_INT_STAT 8'h60
`define BGTM_IDX_INT_MASK 8'h61
// Field positions
`define BGTM_SEL_HI       15
`define BGTM_SEL_LO       14
`define BGTM_LIM_HI       13
`define BGTM_GAIN_HI      1
`define BGTM_IND_EN_BIT   6
`define BGTM_INT_BUF_BIT  7
// Reset values
`define BGTM_PATH_RESET   16'hADA5
`define BGTM_FULL_PATH    16'hADA5
// Exceedance targets per count select code
`define BGTM_TGT_1        5'h01
`define BGTM_TGT_4        5'h04
`define BGTM_TGT_16       5'h10
// Gain decode in kilo-ohm
`define BGTM_KOHM_0       8'hC8
`define BGTM_KOHM_1       8'h64
`define BGTM_KOHM_2       8'h32
`define BGTM_KOHM_3       8'h19
// Bus answers
`define BGTM_RESP_OKAY    2'h0
`define BGTM_RESP_SLVERR  2'h2
`endif

// ### inc/bgtm_pkg.sv
/*
 * Shared types of the background light threshold monitor.
 * Assumes nothing of its surroundings.
 */
package bgtm_pkg;
  typedef logic [13:0] bgtm_limit_t;
  typedef logic [1:0]  bgtm_sel_t;
  typedef logic [4:0]  bgtm_count_t;
endpackage

// ### design/bgtm_exceed_chan.sv
/*
 * One channel's exceedance counter and sticky status flag.
 * Assumes hit and clear are single-cycle pulses on aclk.
 */
`timescale 1ns/100ps
`include "bgtm_map.svh"
module bgtm_exceed_chan (
  // Clock and reset
  input  wire logic             aclk,
  input  wire logic             aresetn,
  // Control
  input  wire logic             hit,
  input  wire logic             clear,
  input  wire bgtm_pkg::bgtm_sel_t sel,
  // Status
  output logic                  flag,
  output logic                  set_evt
);
  bgtm_pkg::bgtm_count_t count;
  bgtm_pkg::bgtm_count_t next_count;
  bgtm_pkg::bgtm_count_t base;
  bgtm_pkg::bgtm_count_t tgt;
  logic                  next_flag;

  // Count, target compare and flag; set wins over read clear
  always_comb begin
    base = clear ? '0 : count;
    next_count = base;
    if (hit && base != `BGTM_TGT_16) begin
      next_count = base + 5'h01;
    end
    unique case (sel)
      2'h1:    tgt = `BGTM_TGT_1;
      2'h2:    tgt = `BGTM_TGT_4;
      2'h3:    tgt = `BGTM_TGT_16;
      default: tgt = '0;
    endcase
    set_evt = (sel != 2'h0) && (next_count >= tgt) && (clear || !flag);
    next_flag = (flag && !clear) || set_evt;
  end

  // State registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= '0;
      flag  <= 1'b0;
    end else begin
      count <= next_count;
      flag  <= next_flag;
    end
  end
endmodule

// ### design/bgtm_axil_slave.sv
/*
 * AXI4-Lite slave front end: one write and one read at a time.
 * Assumes the parent answers rd_data and the hit flags combinationally.
 */
`timescale 1ns/100ps
`include "bgtm_map.svh"
module bgtm_axil_slave (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Write channels
  input  wire logic [11:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // Read channels
  input  wire logic [11:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Register side
  output logic             wr_en,
  output logic [7:0]       wr_idx,
  output logic [31:0]      wr_data,
  output logic [3:0]       wr_strb,
  input  wire logic        wr_hit,
  output logic             rd_en,
  output logic [7:0]       rd_idx,
  input  wire logic [31:0] rd_data,
  input  wire logic        rd_hit
);
  logic aw_got, w_got, next_aw_got, next_w_got;
  logic [7:0]  next_wr_idx;
  logic [31:0] next_wr_data;
  logic [3:0]  next_wr_strb;
  logic next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  // Channel handshakes and answers
  always_comb begin
    next_aw_got  = aw_got;
    next_w_got   = w_got;
    next_wr_idx  = wr_idx;
    next_wr_data = wr_data;
    next_wr_strb = wr_strb;
    next_bvalid  = bvalid && !bready;
    next_bresp   = bresp;
    if (awvalid && awready) begin
      next_aw_got = 1'b1;
      next_wr_idx = awaddr[9:2];
    end
    if (wvalid && wready) begin
      next_w_got   = 1'b1;
      next_wr_data = wdata;
      next_wr_strb = wstrb;
    end
    wr_en = aw_got && w_got && !bvalid;
    if (wr_en) begin
      next_aw_got = 1'b0;
      next_w_got  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = wr_hit ? `BGTM_RESP_OKAY : `BGTM_RESP_SLVERR;
    end
    rd_en  = arvalid && arready;
    rd_idx = araddr[9:2];
    next_rvalid = rvalid && !rready;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rd_en) begin
      next_rvalid = 1'b1;
      next_rdata  = rd_data;
      next_rresp  = rd_hit ? `BGTM_RESP_OKAY : `BGTM_RESP_SLVERR;
    end
  end

  // Channel registers; readies are flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got  <= 1'b0;
      w_got   <= 1'b0;
      wr_idx  <= '0;
      wr_data <= '0;
      wr_strb <= '0;
      bvalid  <= 1'b0;
      bresp   <= `BGTM_RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= `BGTM_RESP_OKAY;
      awready <= 1'b0;
      wready  <= 1'b0;
      arready <= 1'b0;
    end else begin
      aw_got  <= next_aw_got;
      w_got   <= next_w_got;
      wr_idx  <= next_wr_idx;
      wr_data <= next_wr_data;
      wr_strb <= next_wr_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      awready <= !next_aw_got && !next_bvalid;
      wready  <= !next_w_got && !next_bvalid;
      arready <= !next_rvalid;
    end
  end
endmodule

// ### design/bgtm_monitor.sv
/*
 * Background light threshold monitor: per-slot, per-channel exceedance
 * counting in float-mode subtract cycles, read-clear status, slot B
 * amplifier gain and analog path word, interrupt status and mask.
 * Assumes converter results arrive as one-cycle strobes on aclk.
 */
// Overview of operation
// - Slot B gain code 0..3 decodes to 200, 100, 50, 25 kilo-ohm.
// - Per-channel enable gives the code to channel 1; else all four.
// - Slot B analog path word resets to the full path value.
// - Results are compared only in float-mode subtract cycles.
// - A result strictly above the limit bumps that channel's count.
// - Slot A select: never, after one, four or sixteen exceedances.
// - Slot B select uses the same encoding in bits 15 to 14.
// - Slot A channels 1 to 4 report in status bits 0 to 3.
// - Slot B channels 1 to 4 report in status bits 4 to 7.
// - Reading the status returns the flags and then clears them.
// - Slot B has its own 14-bit limit and its own count.
`timescale 1ns/100ps
`include "bgtm_map.svh"
module bgtm_monitor #(
  parameter int CHANNELS = 4
) (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write channels
  input  wire logic [11:0] s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read channels
  input  wire logic [11:0] s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Converter result strobe
  input  wire logic        smp_valid,
  input  wire logic        smp_float_mode,
  input  wire logic        smp_subtract,
  input  wire logic        smp_slot_b,
  input  wire logic [1:0]  smp_channel,
  input  wire logic [13:0] smp_result,
  // Front-end configuration
  output logic [7:0]       slot_b_amp_gain_kohm,
  output logic [3:0]       slot_b_gain_channels,
  output logic             slot_b_integrator_buffer,
  output logic [15:0]      slot_b_analog_path_word,
  output logic             full_analog_path,
  // Interrupt
  output logic             irq
);
  localparam int FLAGS = 2 * CHANNELS;

  // *************************************************************
  // Register bus
  // *************************************************************
  logic        wr_en, rd_en, wr_hit, rd_hit;
  logic [7:0]  wr_idx, rd_idx;
  logic [31:0] wr_data, rd_data;
  logic [3:0]  wr_strb;

  bgtm_axil_slave u_bus (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (s_axi_awaddr),
    .awvalid (s_axi_awvalid),
    .awready (s_axi_awready),
    .wdata   (s_axi_wdata),
    .wstrb   (s_axi_wstrb),
    .wvalid  (s_axi_wvalid),
    .wready  (s_axi_wready),
    .bresp   (s_axi_bresp),
    .bvalid  (s_axi_bvalid),
    .bready  (s_axi_bready),
    .araddr  (s_axi_araddr),
    .arvalid (s_axi_arvalid),
    .arready (s_axi_arready),
    .rdata   (s_axi_rdata),
    .rresp   (s_axi_rresp),
    .rvalid  (s_axi_rvalid),
    .rready  (s_axi_rready),
    .wr_en   (wr_en),
    .wr_idx  (wr_idx),
    .wr_data (wr_data),
    .wr_strb (wr_strb),
    .wr_hit  (wr_hit),
    .rd_en   (rd_en),
    .rd_idx  (rd_idx),
    .rd_data (rd_data),
    .rd_hit  (rd_hit)
  );

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0]  s);
    merge16 = old;
    if (s[0]) merge16[7:0]  = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  // *************************************************************
  // Configuration registers
  // *************************************************************
  logic [15:0] cnt_a, cnt_b, path, next_cnt_a, next_cnt_b, next_path;
  logic [7:0]  gain_cfg, next_gain_cfg;
  logic [FLAGS-1:0] int_stat, int_mask, next_int_stat, next_int_mask;
  logic [FLAGS-1:0] flags, set_evt;
  logic [FLAGS-1:0] hit;
  logic             status_clear;

  // Address decode for writes and reads
  always_comb begin
    wr_hit = (wr_idx == `BGTM_IDX_STATUS) || (wr_idx == `BGTM_IDX_CNT_A) ||
             (wr_idx == `BGTM_IDX_CNT_B)  || (wr_idx == `BGTM_IDX_GAIN)  ||
             (wr_idx == `BGTM_IDX_PATH)   ||
             (wr_idx == `BGTM_IDX_INT_STAT) ||
             (wr_idx == `BGTM_IDX_INT_MASK);
    rd_hit  = 1'b1;
    rd_data = '0;
    unique case (rd_idx)
      `BGTM_IDX_STATUS:   rd_data[FLAGS-1:0] = flags;
      `BGTM_IDX_CNT_A:    rd_data[15:0] = cnt_a;
      `BGTM_IDX_CNT_B:    rd_data[15:0] = cnt_b;
      `BGTM_IDX_GAIN:     rd_data[7:0]  = gain_cfg;
      `BGTM_IDX_PATH:     rd_data[15:0] = path;
      `BGTM_IDX_INT_STAT: rd_data[FLAGS-1:0] = int_stat;
      `BGTM_IDX_INT_MASK: rd_data[FLAGS-1:0] = int_mask;
      default:            rd_hit = 1'b0;
    endcase
    status_clear = rd_en && (rd_idx == `BGTM_IDX_STATUS);
  end

  // Register writes; event set wins over write-one clear
  always_comb begin
    next_cnt_a    = cnt_a;
    next_cnt_b    = cnt_b;
    next_path     = path;
    next_gain_cfg = gain_cfg;
    next_int_mask = int_mask;
    next_int_stat = int_stat;
    if (wr_en) begin
      unique case (wr_idx)
        `BGTM_IDX_CNT_A: next_cnt_a = merge16(cnt_a, wr_data, wr_strb);
        `BGTM_IDX_CNT_B: next_cnt_b = merge16(cnt_b, wr_data, wr_strb);
        `BGTM_IDX_PATH:  next_path  = merge16(path, wr_data, wr_strb);
        `BGTM_IDX_GAIN: begin
          if (wr_strb[0]) next_gain_cfg = wr_data[7:0];
        end
        `BGTM_IDX_INT_MASK: begin
          if (wr_strb[0]) next_int_mask = wr_data[FLAGS-1:0];
        end
        `BGTM_IDX_INT_STAT: begin
          if (wr_strb[0]) next_int_stat = int_stat & ~wr_data[FLAGS-1:0];
        end
        default: next_path = path;
      endcase
    end
    next_int_stat = next_int_stat | set_evt;
  end

  // Configuration state
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_a    <= '0;
      cnt_b    <= '0;
      path     <= `BGTM_PATH_RESET;
      gain_cfg <= '0;
      int_stat <= '0;
      int_mask <= '0;
    end else begin
      cnt_a    <= next_cnt_a;
      cnt_b    <= next_cnt_b;
      path     <= next_path;
      gain_cfg <= next_gain_cfg;
      int_stat <= next_int_stat;
      int_mask <= next_int_mask;
    end
  end

  // *************************************************************
  // Exceedance detection
  // *************************************************************
  // Channels of slot A land in the low nibble, slot B in the high
  genvar g;
  generate
    for (g = 0; g < FLAGS; g++) begin : g_chan
      localparam logic IS_B = (g >= CHANNELS);
      logic [15:0] cfg;
      assign cfg = IS_B ? cnt_b : cnt_a;
      assign hit[g] = smp_valid && smp_float_mode && smp_subtract &&
                      (smp_slot_b == IS_B) &&
                      (smp_channel == 2'(g % CHANNELS)) &&
                      (smp_result > cfg[`BGTM_LIM_HI:0]);
      bgtm_exceed_chan u_chan (
        .aclk    (aclk),
        .aresetn (aresetn),
        .hit     (hit[g]),
        .clear   (status_clear),
        .sel     (cfg[`BGTM_SEL_HI:`BGTM_SEL_LO]),
        .flag    (flags[g]),
        .set_evt (set_evt[g])
      );
    end
  endgenerate

  // *************************************************************
  // Outputs
  // *************************************************************
  logic [7:0] next_kohm;
  logic [3:0] next_chans;

  // Gain decode and channel fan-out
  always_comb begin
    unique case (gain_cfg[`BGTM_GAIN_HI:0])
      2'h0: next_kohm = `BGTM_KOHM_0;
      2'h1: next_kohm = `BGTM_KOHM_1;
      2'h2: next_kohm = `BGTM_KOHM_2;
      2'h3: next_kohm = `BGTM_KOHM_3;
    endcase
    next_chans = gain_cfg[`BGTM_IND_EN_BIT] ? 4'h1 : 4'hF;
  end

  // Output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slot_b_amp_gain_kohm     <= `BGTM_KOHM_0;
      slot_b_gain_channels     <= 4'hF;
      slot_b_integrator_buffer <= 1'b0;
      slot_b_analog_path_word  <= `BGTM_PATH_RESET;
      full_analog_path         <= 1'b1;
      irq                      <= 1'b0;
    end else begin
      slot_b_amp_gain_kohm     <= next_kohm;
      slot_b_gain_channels     <= next_chans;
      slot_b_integrator_buffer <= gain_cfg[`BGTM_INT_BUF_BIT];
      slot_b_analog_path_word  <= path;
      full_analog_path         <= (path == `BGTM_FULL_PATH);
      irq                      <= |(int_stat & int_mask);
    end
  end

  // *************************************************************
  // Checks
  // *************************************************************
  a_gain_decode: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(gain_cfg[1:0]) == 2'h3 && $past(aresetn)
      |-> slot_b_amp_gain_kohm == 8'h19)
    else $error("gain code 3 not 25 kohm");
  a_gain_fanout: assert property (@(posedge aclk) disable iff (!aresetn)
    $past(gain_cfg[6]) && $past(aresetn) |-> slot_b_gain_channels == 4'h1)
    else $error("individual gain not channel 1 only");
  a_path_reset: assert property (@(posedge aclk)
    !aresetn |=> path == 16'hADA5)
    else $error("path word reset value wrong");
  a_no_hit_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    !(smp_float_mode && smp_subtract) |-> hit == '0)
    else $error("hit outside subtract cycle");
  a_flag_once: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_a[15:14] == 2'h1 && hit[0] && !status_clear && !flags[0]
      |=> flags[0])
    else $error("select one did not set flag");
  a_never_set: assert property (@(posedge aclk) disable iff (!aresetn)
    cnt_b[15:14] == 2'h0 |-> !set_evt[CHANNELS])
    else $error("select zero set slot B flag");
  a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    status_clear && set_evt == '0 |=> flags == '0)
    else $error("status not cleared by read");
  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    |(set_evt & int_mask) && !wr_en |=> ##1 irq)
    else $error("masked-in event did not raise interrupt");
endmodule

// ### tb/tb_top.sv
/*
 * Self-checking testbench of the background light threshold monitor.
 * Assumes bgtm_map.svh, bgtm_pkg and the design files are compiled first.
 */
`timescale 1ns/100ps
`include "bgtm_map.svh"
module tb_top;
  // ****************************************
  // Signals
  // ****************************************
  logic        aclk;
  logic        aresetn;
  logic [11:0] s_axi_awaddr;
  logic        s_axi_awvalid;
  logic        s_axi_awready;
  logic [31:0] s_axi_wdata;
  logic [3:0]  s_axi_wstrb;
  logic        s_axi_wvalid;
  logic        s_axi_wready;
  logic [1:0]  s_axi_bresp;
  logic        s_axi_bvalid;
  logic        s_axi_bready;
  logic [11:0] s_axi_araddr;
  logic        s_axi_arvalid;
  logic        s_axi_arready;
  logic [31:0] s_axi_rdata;
  logic [1:0]  s_axi_rresp;
  logic        s_axi_rvalid;
  logic        s_axi_rready;
  logic        smp_valid;
  logic        smp_float_mode;
  logic        smp_subtract;
  logic        smp_slot_b;
  logic [1:0]  smp_channel;
  logic [13:0] smp_result;
  logic [7:0]  slot_b_amp_gain_kohm;
  logic [3:0]  slot_b_gain_channels;
  logic        slot_b_integrator_buffer;
  logic [15:0] slot_b_analog_path_word;
  logic        full_analog_path;
  logic        irq;
  int          errors;
  int          cmp_count;
  // Gain decode in kilo-ohm: 200, 100, 50, 25
  logic [7:0]  kohm_tab [4] = '{8'hC8, 8'h64, 8'h32, 8'h19};
  // Hits before the last one, per count select code
  int          pre_hits [4] = '{16, 0, 3, 15};

  // ****************************************
  // Device under test
  // ****************************************
  bgtm_monitor #(.CHANNELS(4)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .smp_valid(smp_valid),
    .smp_float_mode(smp_float_mode), .smp_subtract(smp_subtract),
    .smp_slot_b(smp_slot_b), .smp_channel(smp_channel),
    .smp_result(smp_result),
    .slot_b_amp_gain_kohm(slot_b_amp_gain_kohm),
    .slot_b_gain_channels(slot_b_gain_channels),
    .slot_b_integrator_buffer(slot_b_integrator_buffer),
    .slot_b_analog_path_word(slot_b_analog_path_word),
    .full_analog_path(full_analog_path), .irq(irq)
  );

  // ****************************************
  // Tasks
  // ****************************************
  // Print counts and verdict, then stop
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Compare one value and count it
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A wait that ran out of its bound
  task automatic give_up();
    errors++;
    tally_and_finish();
  endtask

  // One AXI4-Lite write; address and data offered together
  task automatic wr(input logic [7:0] idx, input logic [31:0] d,
                    input logic [1:0] exp_resp);
    int   n;
    logic got_aw;
    logic got_w;
    @(posedge aclk);
    s_axi_awaddr  <= {2'h0, idx, 2'h0};
    s_axi_awvalid <= 1'b1;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= 4'hF;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    got_aw = 1'b0;
    got_w = 1'b0;
    n = 0;
    while (!(got_aw && got_w)) begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up();
      if (!got_aw && s_axi_awready === 1'b1) begin
        got_aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!got_w && s_axi_wready === 1'b1) begin
        got_w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up();
    end while (s_axi_bvalid !== 1'b1);
    chk({30'h0, s_axi_bresp}, {30'h0, exp_resp});
    s_axi_bready <= 1'b0;
  endtask

  // One AXI4-Lite read, compared with expected data and response
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp_d,
                    input logic [1:0] exp_resp);
    int n;
    @(posedge aclk);
    s_axi_araddr  <= {2'h0, idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up();
    end while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (n > 50) give_up();
    end while (s_axi_rvalid !== 1'b1);
    chk(s_axi_rdata, exp_d);
    chk({30'h0, s_axi_rresp}, {30'h0, exp_resp});
    s_axi_rready <= 1'b0;
  endtask

  // One converter result strobe with its qualifiers
  task automatic smp(input logic b, input logic [1:0] ch,
                     input logic [13:0] res, input logic fl, input logic sb);
    @(posedge aclk);
    smp_valid      <= 1'b1;
    smp_slot_b     <= b;
    smp_channel    <= ch;
    smp_result     <= res;
    smp_float_mode <= fl;
    smp_subtract   <= sb;
    @(posedge aclk);
    smp_valid      <= 1'b0;
  endtask

  // ****************************************
  // Clock and stimulus
  // ****************************************
  // Free-running 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // Main sequence
  initial begin
    errors = 0;
    cmp_count = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid} = '0;
    {s_axi_rready, smp_valid, smp_float_mode, smp_subtract} = '0;
    {smp_slot_b, smp_channel, smp_result} = '0;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset values of registers and front-end outputs
    rd(`BGTM_IDX_PATH, 32'h0000ADA5, `BGTM_RESP_OKAY);
    rd(`BGTM_IDX_STATUS, 32'h0, `BGTM_RESP_OKAY);
    rd(`BGTM_IDX_CNT_A, 32'h0, `BGTM_RESP_OKAY);
    rd(`BGTM_IDX_CNT_B, 32'h0, `BGTM_RESP_OKAY);
    rd(`BGTM_IDX_GAIN, 32'h0, `BGTM_RESP_OKAY);
    chk({31'h0, full_analog_path}, 32'h1);
    rd(8'h70, 32'h0, `BGTM_RESP_SLVERR);
    wr(8'h70, 32'h1, `BGTM_RESP_SLVERR);
    $display("Test reset and map done");
    // Every gain code with per-channel enable off and on
    for (int i = 0; i < 8; i++) begin
      wr(`BGTM_IDX_GAIN, {25'h0, i[2], 4'h0, i[1:0]}, `BGTM_RESP_OKAY);
      repeat (2) @(posedge aclk);
      chk({24'h0, slot_b_amp_gain_kohm}, {24'h0, kohm_tab[i[1:0]]});
      chk({28'h0, slot_b_gain_channels}, i[2] ? 32'h1 : 32'hF);
    end
    $display("Test gain decode done");
    // Buffered path with both buffer bits, then the other two codes
    wr(`BGTM_IDX_GAIN, 32'h80, `BGTM_RESP_OKAY);
    wr(`BGTM_IDX_PATH, 32'hAE65, `BGTM_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, slot_b_integrator_buffer}, 32'h1);
    chk({16'h0, slot_b_analog_path_word}, 32'hAE65);
    chk({31'h0, full_analog_path}, 32'h0);
    wr(`BGTM_IDX_GAIN, 32'h0, `BGTM_RESP_OKAY);
    wr(`BGTM_IDX_PATH, 32'hB065, `BGTM_RESP_OKAY);
    rd(`BGTM_IDX_PATH, 32'hB065, `BGTM_RESP_OKAY);
    wr(`BGTM_IDX_PATH, 32'hADA5, `BGTM_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, full_analog_path}, 32'h1);
    chk({31'h0, slot_b_integrator_buffer}, 32'h0);
    $display("Test analog path done");
    // Each count select: no flag one hit short, flag at the target
    for (int s = 0; s < 4; s++) begin
      wr(`BGTM_IDX_CNT_A, {16'h0, s[1:0], 14'h0100}, `BGTM_RESP_OKAY);
      wr(`BGTM_IDX_INT_STAT, 32'hFF, `BGTM_RESP_OKAY);
      for (int h = 0; h < pre_hits[s]; h++) begin
        smp(1'b0, 2'h0, 14'h0101, 1'b1, 1'b1);
      end
      smp(1'b0, 2'h0, 14'h0100, 1'b1, 1'b1);
      smp(1'b0, 2'h0, 14'h3FFF, 1'b0, 1'b1);
      smp(1'b0, 2'h0, 14'h3FFF, 1'b1, 1'b0);
      rd(`BGTM_IDX_INT_STAT, 32'h0, `BGTM_RESP_OKAY);
      smp(1'b0, 2'h0, 14'h0101, 1'b1, 1'b1);
      rd(`BGTM_IDX_STATUS, (s == 0) ? 32'h0 : 32'h1, `BGTM_RESP_OKAY);
      rd(`BGTM_IDX_STATUS, 32'h0, `BGTM_RESP_OKAY);
    end
    $display("Test count select done");
    // Slot B select zero must never flag, even on a hit
    smp(1'b1, 2'h0, 14'h0101, 1'b1, 1'b1);
    // Read clear restarts the count: three hits, read, three more, read, then four more
    wr(`BGTM_IDX_CNT_B, 32'h0000A000, `BGTM_RESP_OKAY);
    for (int h = 0; h < 3; h++) smp(1'b1, 2'h1, 14'h2001, 1'b1, 1'b1);
    rd(`BGTM_IDX_STATUS, 32'h0, `BGTM_RESP_OKAY);
    for (int h = 0; h < 3; h++) smp(1'b1, 2'h1, 14'h2001, 1'b1, 1'b1);
    rd(`BGTM_IDX_STATUS, 32'h0, `BGTM_RESP_OKAY);
    for (int h = 0; h < 4; h++) smp(1'b1, 2'h1, 14'h2001, 1'b1, 1'b1);
    rd(`BGTM_IDX_STATUS, 32'h20, `BGTM_RESP_OKAY);
    $display("Test read clear done");
    // Bit position of every slot and channel, each slot on its own limit
    wr(`BGTM_IDX_CNT_A, 32'h00004100, `BGTM_RESP_OKAY);
    wr(`BGTM_IDX_CNT_B, 32'h00006000, `BGTM_RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      if (k[2]) begin
        smp(1'b1, k[1:0], 14'h2000, 1'b1, 1'b1);
        rd(`BGTM_IDX_STATUS, 32'h0, `BGTM_RESP_OKAY);
      end
      smp(k[2], k[1:0], k[2] ? 14'h2001 : 14'h0101, 1'b1, 1'b1);
      rd(`BGTM_IDX_STATUS, 32'h1 << k, `BGTM_RESP_OKAY);
      rd(`BGTM_IDX_STATUS, 32'h0, `BGTM_RESP_OKAY);
    end
    $display("Test flag mapping done");
    // Interrupt raised, masked, unmasked and cleared
    wr(`BGTM_IDX_INT_STAT, 32'hFF, `BGTM_RESP_OKAY);
    smp(1'b0, 2'h2, 14'h0101, 1'b1, 1'b1);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    wr(`BGTM_IDX_INT_MASK, 32'h04, `BGTM_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    rd(`BGTM_IDX_INT_STAT, 32'h04, `BGTM_RESP_OKAY);
    wr(`BGTM_IDX_INT_STAT, 32'h04, `BGTM_RESP_OKAY);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h0);
    rd(`BGTM_IDX_STATUS, 32'h04, `BGTM_RESP_OKAY);
    // A fresh event while already masked in raises the line again
    smp(1'b0, 2'h2, 14'h0101, 1'b1, 1'b1);
    repeat (3) @(posedge aclk);
    chk({31'h0, irq}, 32'h1);
    $display("Test interrupt done");
    tally_and_finish();
  end
endmodule
